/* File: common/epv_regs.svh */
// Register map, field positions, reset values and vector constants
`ifndef EPV_REGS_SVH
`define EPV_REGS_SVH

// Register byte offsets
`define EPV_OFS_COND       8'h00
`define EPV_OFS_PRIO       8'h04
`define EPV_OFS_INTCTL     8'h08
`define EPV_OFS_WDCTL      8'h0c
`define EPV_OFS_PACC       8'h10
`define EPV_OFS_SPI        8'h14
`define EPV_OFS_PACC2      8'h18
`define EPV_OFS_MODCTL     8'h1c
`define EPV_OFS_LOCEN      8'h20
`define EPV_OFS_STATUS     8'h24

// Field positions
`define EPV_COND_X_BIT     6
`define EPV_COND_I_BIT     4
`define EPV_INT_EDGE_BIT   7
`define EPV_INT_CONN_BIT   6
`define EPV_WD_CLKMON_BIT  7
`define EPV_WD_FORCE_BIT   6
`define EPV_WD_RATE_HI     2
`define EPV_PACC_OVF_BIT   1
`define EPV_PACC_EDGE_BIT  0
`define EPV_SPI_IE_BIT     7
`define EPV_PACC2_OVF_BIT  1
`define EPV_MOD_UF_BIT     7
`define EPV_ST_VALID_BIT   16
`define EPV_ST_LATCH_BIT   17

// Reset values
`define EPV_RST_COND       8'h50
`define EPV_RST_PRIO       8'hf2
`define EPV_RST_INTCTL     8'h40

// Vectors
`define EPV_VEC_RESET      16'hfffe
`define EPV_VEC_CLKMON     16'hfffc
`define EPV_VEC_WDOG       16'hfffa
`define EPV_VEC_TRAP       16'hfff8
`define EPV_VEC_SWTRAP     16'hfff6
`define EPV_VEC_XPIN       16'hfff4
`define EPV_VEC_MASK_TOP   16'hfff2
`define EPV_VEC_RESV_LO    16'hff80
`define EPV_VEC_RESV_HI    16'hffc1
`define EPV_NUM_MASK       25

// Elevation values of the sources with dedicated enables
`define EPV_ELV_PACC_OVF   8'hdc
`define EPV_ELV_PACC_EDGE  8'hda
`define EPV_ELV_SPI        8'hd8
`define EPV_ELV_MOD_UF     8'hcc
`define EPV_ELV_PACC2_OVF  8'hca
`define EPV_ELV_TOP        8'hf2

`endif

/* File: common/epv_pkg.sv */
// Types shared by the exception vectoring block
package epv_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } epv_apb_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
  } epv_vec_t;

endpackage : epv_pkg

/* File: logic/epv_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module epv_sync #(
  parameter int          WIDTH    = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end

endmodule : epv_sync

/* File: logic/epv_top.sv */
// Exception arbitration and vectoring with APB register slave
`timescale 1ns/1ps
`include "epv_regs.svh"
module epv_top #(
  parameter int NUM_MASK = `EPV_NUM_MASK
) (
  // Clock and reset
  input  wire logic                CLK_SYS,
  input  wire logic                RESET,
  // APB slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // Non-maskable requests from core logic
  input  wire logic                RST_REQ,
  input  wire logic                CLKMON_FAIL,
  input  wire logic                WDOG_TIMEOUT,
  input  wire logic                TRAP_OP_REQ,
  input  wire logic                SWTRAP_OP_REQ,
  // External pins, active low
  input  wire logic                EXT_NONMASKABLE_PIN_REQ_N,
  input  wire logic                EXT_MASKABLE_PIN_N,
  // Peripheral request flags, slot 0 unused (external pin)
  input  wire logic [NUM_MASK-1:0] PERIPH_REQ,
  // Exception sequencer
  input  wire logic                SVC_FETCH,
  output logic                     EXC_PENDING,
  output logic      [15:0]         EXC_VECTOR,
  output logic                     FETCH_VALID,
  output logic      [15:0]         FETCH_VECTOR,
  output logic                     GLOBAL_MASK
);

  // Pin synchronisation
  logic [1:0] pins_s;
  logic       xpin_lvl_n;
  logic       ipin_lvl_n;

  epv_sync #(
    .WIDTH   (2),
    .RST_VAL (2'h3)
  ) u_pin_sync (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .din  ({EXT_NONMASKABLE_PIN_REQ_N, EXT_MASKABLE_PIN_N}),
    .dout (pins_s)
  );

  assign xpin_lvl_n = pins_s[1];
  assign ipin_lvl_n = pins_s[0];

  // Bus request bundle
  epv_pkg::epv_apb_req_t apb;

  always_comb begin
    apb.psel    = PSEL;
    apb.penable = PENABLE;
    apb.pwrite  = PWRITE;
    apb.paddr   = PADDR;
    apb.pwdata  = PWDATA;
  end

  // Registers
  logic [7:0]          cond_r,  cond_nxt;
  logic [7:0]          prio_r,  prio_nxt;
  logic [7:0]          intc_r,  intc_nxt;
  logic [7:0]          wdc_r,   wdc_nxt;
  logic [7:0]          pacc_r,  pacc_nxt;
  logic [7:0]          spi_r,   spi_nxt;
  logic [7:0]          pacc2_r, pacc2_nxt;
  logic [7:0]          mod_r,   mod_nxt;
  logic [NUM_MASK-1:0] locen_r, locen_nxt;
  logic [31:0]         prdata_nxt;
  logic                pready_nxt;
  logic                pslverr_nxt;
  logic                wr_en;
  logic                setup;
  logic                mapped;

  // Arbitration signals
  logic [NUM_MASK-1:0] mask_en;
  logic [NUM_MASK-1:0] mask_req;
  logic                irq_req;
  logic                ipin_prev_r, ipin_prev_nxt;
  logic                edge_latch_r, edge_latch_nxt;
  logic                irq_fall;
  logic [7:0]          promo_diff;
  logic [7:0]          promo_idx;
  logic                promo_ok;
  epv_pkg::epv_vec_t   win;
  logic                found;
  logic                fetch_valid_nxt;
  logic [15:0]         fetch_vec_nxt;
  logic                fetch_irq;

  // Vector address of maskable slot
  function automatic logic [15:0] slot_vec(input int idx);
    logic [15:0] ofs;
    ofs = 16'(idx) << 1;
    return `EPV_VEC_MASK_TOP - ofs;
  endfunction : slot_vec

  // Slot index of an elevation value
  function automatic int elv_slot(input logic [7:0] elv);
    return int'((`EPV_ELV_TOP - elv) >> 1);
  endfunction : elv_slot

  // Local enable per maskable slot
  generate
    for (genvar g = 0; g < NUM_MASK; g++) begin : g_en
      always_comb begin
        if (g == 0) begin
          mask_en[g] = intc_r[`EPV_INT_CONN_BIT];
        end else if (g == elv_slot(`EPV_ELV_PACC_OVF)) begin
          mask_en[g] = pacc_r[`EPV_PACC_OVF_BIT];
        end else if (g == elv_slot(`EPV_ELV_PACC_EDGE)) begin
          mask_en[g] = pacc_r[`EPV_PACC_EDGE_BIT];
        end else if (g == elv_slot(`EPV_ELV_SPI)) begin
          mask_en[g] = spi_r[`EPV_SPI_IE_BIT];
        end else if (g == elv_slot(`EPV_ELV_MOD_UF)) begin
          mask_en[g] = mod_r[`EPV_MOD_UF_BIT];
        end else if (g == elv_slot(`EPV_ELV_PACC2_OVF)) begin
          mask_en[g] = pacc2_r[`EPV_PACC2_OVF_BIT];
        end else begin
          mask_en[g] = locen_r[g];
        end
      end
      always_comb begin
        if (g == 0) begin
          mask_req[g] = irq_req & mask_en[g];
        end else begin
          mask_req[g] = PERIPH_REQ[g] & mask_en[g];
        end
      end
    end
  endgenerate

  // External maskable pin
  always_comb begin
    ipin_prev_nxt = ipin_lvl_n;
    irq_fall      = ipin_prev_r & ~ipin_lvl_n;
    // latch cleared on service, set wins
    edge_latch_nxt = edge_latch_r & ~fetch_irq;
    if (irq_fall && intc_r[`EPV_INT_EDGE_BIT]) begin
      edge_latch_nxt = 1'b1;
    end
    if (!intc_r[`EPV_INT_EDGE_BIT]) begin
      edge_latch_nxt = 1'b0;
    end
    if (intc_r[`EPV_INT_EDGE_BIT]) begin
      irq_req = edge_latch_r;
    end else begin
      irq_req = ~ipin_lvl_n;
    end
  end

  // Promotion decode
  always_comb begin
    promo_diff = `EPV_ELV_TOP - prio_r;
    promo_idx  = {1'b0, promo_diff[7:1]};
    promo_ok   = (prio_r <= `EPV_ELV_TOP) && !prio_r[0] &&
                 (promo_idx < 8'(NUM_MASK));
  end

  always_comb begin
    win.valid  = 1'b0;
    win.vector = `EPV_VEC_TRAP;
    found      = 1'b0;
    if (RST_REQ) begin
      win.vector = `EPV_VEC_RESET;
      found      = 1'b1;
    end else if (CLKMON_FAIL &&
                 (wdc_r[`EPV_WD_CLKMON_BIT] || wdc_r[`EPV_WD_FORCE_BIT])) begin
      win.vector = `EPV_VEC_CLKMON;
      found      = 1'b1;
    end else if (WDOG_TIMEOUT && (wdc_r[`EPV_WD_RATE_HI:0] != 3'h0)) begin
      win.vector = `EPV_VEC_WDOG;
      found      = 1'b1;
    end else if (TRAP_OP_REQ) begin
      win.vector = `EPV_VEC_TRAP;
      found      = 1'b1;
    end else if (SWTRAP_OP_REQ) begin
      win.vector = `EPV_VEC_SWTRAP;
      found      = 1'b1;
    end else if (!xpin_lvl_n && !cond_r[`EPV_COND_X_BIT]) begin
      win.vector = `EPV_VEC_XPIN;
      found      = 1'b1;
    end else if (!cond_r[`EPV_COND_I_BIT]) begin
      if (promo_ok && mask_req[promo_idx[4:0]]) begin
        win.vector = slot_vec(int'(promo_idx));
        found      = 1'b1;
      end else begin
        for (int i = NUM_MASK - 1; i >= 0; i--) begin
          if (mask_req[i]) begin
            win.vector = slot_vec(i);
            found      = 1'b1;
          end
        end
      end
    end
    win.valid = found;
  end

  // Service fetch
  always_comb begin
    fetch_valid_nxt = SVC_FETCH;
    fetch_vec_nxt   = FETCH_VECTOR;
    fetch_irq       = 1'b0;
    if (SVC_FETCH) begin
      fetch_vec_nxt = win.valid ? win.vector : `EPV_VEC_TRAP;
      fetch_irq     = win.valid && (win.vector == `EPV_VEC_MASK_TOP);
    end
  end

  // APB decode
  always_comb begin
    setup = apb.psel && !apb.penable;
    wr_en = apb.psel && apb.penable && apb.pwrite && PREADY;
    case (apb.paddr)
      `EPV_OFS_COND, `EPV_OFS_PRIO, `EPV_OFS_INTCTL, `EPV_OFS_WDCTL,
      `EPV_OFS_PACC, `EPV_OFS_SPI, `EPV_OFS_PACC2, `EPV_OFS_MODCTL,
      `EPV_OFS_LOCEN, `EPV_OFS_STATUS: mapped = 1'b1;
      default:                         mapped = 1'b0;
    endcase
  end

  // Register next values
  always_comb begin
    cond_nxt  = cond_r;
    prio_nxt  = prio_r;
    intc_nxt  = intc_r;
    wdc_nxt   = wdc_r;
    pacc_nxt  = pacc_r;
    spi_nxt   = spi_r;
    pacc2_nxt = pacc2_r;
    mod_nxt   = mod_r;
    locen_nxt = locen_r;
    if (wr_en) begin
      case (apb.paddr)
        `EPV_OFS_COND:   cond_nxt  = apb.pwdata[7:0];
        `EPV_OFS_PRIO:   prio_nxt  = cond_r[`EPV_COND_I_BIT] ? apb.pwdata[7:0] : prio_r;
        `EPV_OFS_INTCTL: intc_nxt  = apb.pwdata[7:0];
        `EPV_OFS_WDCTL:  wdc_nxt   = apb.pwdata[7:0];
        `EPV_OFS_PACC:   pacc_nxt  = apb.pwdata[7:0];
        `EPV_OFS_SPI:    spi_nxt   = apb.pwdata[7:0];
        `EPV_OFS_PACC2:  pacc2_nxt = apb.pwdata[7:0];
        `EPV_OFS_MODCTL: mod_nxt   = apb.pwdata[7:0];
        `EPV_OFS_LOCEN:  locen_nxt = apb.pwdata[NUM_MASK-1:0];
        default:         cond_nxt  = cond_r;
      endcase
    end
  end

  // Read data prepared in setup cycle
  always_comb begin
    prdata_nxt  = PRDATA;
    pready_nxt  = setup;
    pslverr_nxt = 1'b0;
    if (setup) begin
      pslverr_nxt = !mapped;
      case (apb.paddr)
        `EPV_OFS_COND:   prdata_nxt = {24'h0, cond_r};
        `EPV_OFS_PRIO:   prdata_nxt = {24'h0, prio_r};
        `EPV_OFS_INTCTL: prdata_nxt = {24'h0, intc_r};
        `EPV_OFS_WDCTL:  prdata_nxt = {24'h0, wdc_r};
        `EPV_OFS_PACC:   prdata_nxt = {24'h0, pacc_r};
        `EPV_OFS_SPI:    prdata_nxt = {24'h0, spi_r};
        `EPV_OFS_PACC2:  prdata_nxt = {24'h0, pacc2_r};
        `EPV_OFS_MODCTL: prdata_nxt = {24'h0, mod_r};
        `EPV_OFS_LOCEN:  prdata_nxt = {{(32-NUM_MASK){1'b0}}, locen_r};
        `EPV_OFS_STATUS: prdata_nxt = {14'h0, edge_latch_r, win.valid, win.vector};
        default:         prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cond_r       <= `EPV_RST_COND;
      prio_r       <= `EPV_RST_PRIO;
      intc_r       <= `EPV_RST_INTCTL;
      wdc_r        <= 8'h00;
      pacc_r       <= 8'h00;
      spi_r        <= 8'h00;
      pacc2_r      <= 8'h00;
      mod_r        <= 8'h00;
      locen_r      <= '0;
      PRDATA       <= 32'h0;
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
      ipin_prev_r  <= 1'b1;
      edge_latch_r <= 1'b0;
      EXC_PENDING  <= 1'b0;
      EXC_VECTOR   <= `EPV_VEC_RESET;
      FETCH_VALID  <= 1'b0;
      FETCH_VECTOR <= `EPV_VEC_RESET;
      GLOBAL_MASK  <= 1'b1;
    end else begin
      cond_r       <= cond_nxt;
      prio_r       <= prio_nxt;
      intc_r       <= intc_nxt;
      wdc_r        <= wdc_nxt;
      pacc_r       <= pacc_nxt;
      spi_r        <= spi_nxt;
      pacc2_r      <= pacc2_nxt;
      mod_r        <= mod_nxt;
      locen_r      <= locen_nxt;
      PRDATA       <= prdata_nxt;
      PREADY       <= pready_nxt;
      PSLVERR      <= pslverr_nxt;
      ipin_prev_r  <= ipin_prev_nxt;
      edge_latch_r <= edge_latch_nxt;
      EXC_PENDING  <= win.valid;
      EXC_VECTOR   <= win.vector;
      FETCH_VALID  <= fetch_valid_nxt;
      FETCH_VECTOR <= fetch_vec_nxt;
      GLOBAL_MASK  <= cond_nxt[`EPV_COND_I_BIT];
    end
  end

  // slots end at FFC2, above the reserved range

endmodule : epv_top

/* File: verif/epv_top_asserts.sv */
// Port-level checks for the exception vectoring block
`timescale 1ns/1ps
module epv_top_asserts #(
  parameter int NUM_MASK = 25
) (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  // Register bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Non-maskable requests
  input wire logic        RST_REQ,
  input wire logic        CLKMON_FAIL,
  input wire logic        WDOG_TIMEOUT,
  input wire logic        TRAP_OP_REQ,
  input wire logic        SWTRAP_OP_REQ,
  // Sequencer
  input wire logic        SVC_FETCH,
  input wire logic        EXC_PENDING,
  input wire logic [15:0] EXC_VECTOR,
  input wire logic        FETCH_VALID,
  input wire logic [15:0] FETCH_VECTOR,
  input wire logic        GLOBAL_MASK
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_ready_access: assert property (PSEL && !PENABLE |=> PREADY && PENABLE)
    else $error("No ready in access cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("Error without ready");
  a_reset_first: assert property (RST_REQ |=> EXC_PENDING && EXC_VECTOR == 16'hfffe)
    else $error("Reset vector not first");
  a_trap_rank: assert property (
    TRAP_OP_REQ && !RST_REQ && !CLKMON_FAIL && !WDOG_TIMEOUT
    |=> EXC_PENDING && EXC_VECTOR == 16'hfff8) else $error("Trap vector wrong");
  a_swtrap_rank: assert property (
    SWTRAP_OP_REQ && !TRAP_OP_REQ && !RST_REQ && !CLKMON_FAIL && !WDOG_TIMEOUT
    |=> EXC_PENDING && EXC_VECTOR == 16'hfff6) else $error("Software trap vector wrong");
  a_mask_gate: assert property (EXC_PENDING && EXC_VECTOR < 16'hfff4 |-> !$past(GLOBAL_MASK))
    else $error("Maskable taken while masked");
  a_vec_window: assert property (EXC_VECTOR[15:7] == 9'h1ff && !EXC_VECTOR[0])
    else $error("Vector outside top window");
  a_resv_free: assert property (EXC_PENDING |-> !(EXC_VECTOR inside {[16'hff80:16'hffc1]}))
    else $error("Reserved vector used");
  a_fetch_vec: assert property (SVC_FETCH |=> FETCH_VALID && FETCH_VECTOR == EXC_VECTOR)
    else $error("Fetch vector wrong");
  a_fetch_cause: assert property (FETCH_VALID |-> $past(SVC_FETCH))
    else $error("Fetch pulse without request");

  c_slverr: cover property (PSLVERR);
  c_fetch_pin: cover property (SVC_FETCH ##1 FETCH_VECTOR == 16'hfff2);
  c_promoted: cover property (EXC_PENDING && EXC_VECTOR == 16'hffcc);
endmodule : epv_top_asserts

/* File: verif/epv_far_model.sv */
// Behavioural peripherals and interrupt pins facing the block
`timescale 1ns/1ps
module epv_far_model #(
  parameter int N = 25
) (
  // Clock
  input  wire logic         clk,
  // Requests toward the block
  output logic      [N-1:0] periph_req,
  output logic              pin_n,
  output logic              xpin_n
);
  // Pins idle high through pull-ups
  initial begin
    periph_req = '0;
    pin_n = 1'b1;
    xpin_n = 1'b1;
  end
  // levels held until the owner releases them, except pin_pulse, which drives pin_n low for 3 clocks and releases it
  task automatic set_reqs(input logic [N-1:0] v);
    periph_req <= v;
  endtask : set_reqs
  task automatic set_pin(input logic v);
    pin_n <= v;
  endtask : set_pin
  task automatic set_xpin(input logic v);
    xpin_n <= v;
  endtask : set_xpin
  task automatic pin_pulse();
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    pin_n <= 1'b1;
  endtask : pin_pulse
endmodule : epv_far_model

/* File: verif/epv_top_tb.sv */
// Self-checking bench for the exception vectoring block
`timescale 1ns/1ps
`include "epv_regs.svh"
module epv_top_tb;
  logic        clk, rst, psel, penable, pwrite, svc, pend, fv, gm, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0]  nm;
  logic [15:0] evec, fvec;
  logic [24:0] preq;
  logic        pin_n, xpin_n;
  int          err_count, checks_done;

  epv_top u_dut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RST_REQ(nm[4]), .CLKMON_FAIL(nm[3]), .WDOG_TIMEOUT(nm[2]), .TRAP_OP_REQ(nm[1]),
    .SWTRAP_OP_REQ(nm[0]), .EXT_NONMASKABLE_PIN_REQ_N(xpin_n), .EXT_MASKABLE_PIN_N(pin_n),
    .PERIPH_REQ(preq), .SVC_FETCH(svc), .EXC_PENDING(pend), .EXC_VECTOR(evec),
    .FETCH_VALID(fv), .FETCH_VECTOR(fvec), .GLOBAL_MASK(gm));
  epv_far_model u_far (.clk(clk), .periph_req(preq), .pin_n(pin_n), .xpin_n(xpin_n));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm_s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm_s, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
    if (n >= 16) begin
      err_count++;
      report_and_stop();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk("read data", e, rdat);
    chk("slave error", ee, rerr);
  endtask : rd

  task automatic vec(input logic p, input logic [15:0] v);
    repeat (4) @(posedge clk);
    chk("exc pending", p, pend);
    chk("exc vector", v, evec);
  endtask : vec

  task automatic fetch(input logic [15:0] v);
    svc <= 1'b1;
    @(posedge clk);
    svc <= 1'b0;
    @(posedge clk);
    chk("fetch valid", 1'b1, fv);
    chk("fetch vector", v, fvec);
  endtask : fetch

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    int k;
    int sl [6] = '{1, 11, 12, 13, 19, 20};
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    svc = 1'b0; nm = 5'h0; err_count = 0; checks_done = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`EPV_OFS_COND, 32'h50, 1'b0);
    rd(`EPV_OFS_PRIO, 32'hf2, 1'b0);
    rd(`EPV_OFS_INTCTL, 32'h40, 1'b0);
    rd(8'h28, 32'h0, 1'b1);
    chk("global mask", 1'b1, gm);
    u_far.set_xpin(1'b0);
    vec(1'b0, 16'hfff8);
    wr(`EPV_OFS_COND, 32'h10);
    wr(`EPV_OFS_WDCTL, 32'h81);
    nm <= 5'h1f;
    for (k = 0; k < 5; k++) begin
      vec(1'b1, 16'hfffe - 16'(2 * k));
      nm <= 5'(5'h1f >> (k + 1));
    end
    vec(1'b1, 16'hfff4);
    u_far.set_xpin(1'b1);
    wr(`EPV_OFS_WDCTL, 32'h0);
    nm <= 5'h0c;
    vec(1'b0, 16'hfff8);
    wr(`EPV_OFS_WDCTL, 32'h40);
    vec(1'b1, 16'hfffc);
    nm <= 5'h0;
    $display("non-maskable order test done");
    wr(`EPV_OFS_PACC, 32'h3);
    wr(`EPV_OFS_SPI, 32'h80);
    wr(`EPV_OFS_PACC2, 32'h2);
    wr(`EPV_OFS_MODCTL, 32'h80);
    wr(`EPV_OFS_LOCEN, 32'h1fffffe);
    u_far.set_reqs(25'h800);
    vec(1'b0, 16'hfff8);
    wr(`EPV_OFS_COND, 32'h0);
    chk("global mask", 1'b0, gm);
    for (k = 0; k < 6; k++) begin
      u_far.set_reqs(25'h1 << sl[k]);
      vec(1'b1, 16'hfff2 - 16'(2 * sl[k]));
    end
    wr(`EPV_OFS_SPI, 32'h0);
    u_far.set_reqs(25'h2000);
    vec(1'b0, 16'hfff8);
    wr(`EPV_OFS_SPI, 32'h80);
    $display("maskable vector test done");
    wr(`EPV_OFS_COND, 32'h10);
    wr(`EPV_OFS_PRIO, 32'hcc);
    rd(`EPV_OFS_PRIO, 32'hcc, 1'b0);
    u_far.set_reqs(25'h82800);
    wr(`EPV_OFS_COND, 32'h0);
    vec(1'b1, 16'hffcc);
    u_far.set_reqs(25'h2800);
    vec(1'b1, 16'hffdc);
    wr(`EPV_OFS_PRIO, 32'hdc);
    rd(`EPV_OFS_PRIO, 32'hcc, 1'b0);
    u_far.set_reqs(25'h80800);
    wr(`EPV_OFS_MODCTL, 32'h0);
    vec(1'b1, 16'hffdc);
    wr(`EPV_OFS_COND, 32'h10);
    vec(1'b0, 16'hfff8);
    wr(`EPV_OFS_PRIO, 32'hf2);
    u_far.set_reqs(25'h0);
    $display("promotion test done");
    wr(`EPV_OFS_INTCTL, 32'hc0);
    wr(`EPV_OFS_COND, 32'h0);
    u_far.pin_pulse();
    vec(1'b1, 16'hfff2);
    rd(`EPV_OFS_STATUS, 32'h0003fff2, 1'b0);
    fetch(16'hfff2);
    vec(1'b0, 16'hfff8);
    wr(`EPV_OFS_INTCTL, 32'h40);
    u_far.set_pin(1'b0);
    vec(1'b1, 16'hfff2);
    u_far.set_pin(1'b1);
    vec(1'b0, 16'hfff8);
    fetch(16'hfff8);
    $display("pin and fetch test done");
    report_and_stop();
  end
endmodule : epv_top_tb

bind epv_top epv_top_asserts #(.NUM_MASK(NUM_MASK)) u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .RST_REQ(RST_REQ),
  .CLKMON_FAIL(CLKMON_FAIL), .WDOG_TIMEOUT(WDOG_TIMEOUT), .TRAP_OP_REQ(TRAP_OP_REQ),
  .SWTRAP_OP_REQ(SWTRAP_OP_REQ), .SVC_FETCH(SVC_FETCH), .EXC_PENDING(EXC_PENDING),
  .EXC_VECTOR(EXC_VECTOR), .FETCH_VALID(FETCH_VALID), .FETCH_VECTOR(FETCH_VECTOR),
  .GLOBAL_MASK(GLOBAL_MASK));
